// ==== design/tccc_pkg.sv ====
// package for the timer capture/compare channel pair
// assumes one kernel clock and a sampling strobe supplied by the time-base
package tccc_pkg;
    localparam int TCCC_CNT_W = 16;
    localparam int TCCC_ADDR_W = 4;
    // register offsets, word addresses of the plain register port
    localparam logic [3:0] TCCC_OFF_MODE = 4'h0;
    localparam logic [3:0] TCCC_OFF_ENABLE = 4'h1;
    localparam logic [3:0] TCCC_OFF_IRQEN = 4'h2;
    localparam logic [3:0] TCCC_OFF_STATUS = 4'h3;
    localparam logic [3:0] TCCC_OFF_CCR1 = 4'h4;
    localparam logic [3:0] TCCC_OFF_CCR2 = 4'h5;
    localparam logic [3:0] TCCC_OFF_SLAVE = 4'h6;
    // mode register field positions, channel 1 in bits 7:0, channel 2 in 15:8
    localparam int TCCC_DIR_LSB = 0;
    localparam int TCCC_PSC_LSB = 2;
    localparam int TCCC_FLT_LSB = 4;
    localparam int TCCC_OCM_LSB = 4;
    localparam int TCCC_OPE_BIT = 3;
    localparam int TCCC_CH2_SHIFT = 8;
    // enable register: per channel enable, polarity, complementary polarity
    localparam int TCCC_EN_BIT = 0;
    localparam int TCCC_POL_BIT = 1;
    localparam int TCCC_NPOL_BIT = 3;
    localparam int TCCC_EN_CH2_SHIFT = 4;
    // status register bits
    localparam int TCCC_SR_CC1 = 1;
    localparam int TCCC_SR_CC2 = 2;
    localparam int TCCC_SR_TRG = 6;
    localparam int TCCC_SR_OF1 = 9;
    localparam int TCCC_SR_OF2 = 10;
    // slave register fields
    localparam int TCCC_SMS_LSB = 0;
    localparam int TCCC_TS_LSB = 4;
    localparam logic [2:0] TCCC_SMS_RESET = 3'h4;
    localparam logic [2:0] TCCC_TS_IN1 = 3'h5;
    localparam logic [2:0] TCCC_TS_IN2 = 3'h6;
    // direction codes
    localparam logic [1:0] TCCC_DIR_OUT = 2'h0;
    localparam logic [1:0] TCCC_DIR_OWN = 2'h1;
    localparam logic [1:0] TCCC_DIR_CROSS = 2'h2;
    // reset values
    localparam logic [15:0] TCCC_RST_REG = 16'h0000;
    localparam logic [15:0] TCCC_RST_CCR = 16'h0000;

    typedef enum logic [2:0] {
        TCCC_OC_FROZEN,
        TCCC_OC_ACTIVE,
        TCCC_OC_INACTIVE,
        TCCC_OC_TOGGLE,
        TCCC_OC_FORCE_LOW,
        TCCC_OC_FORCE_HIGH,
        TCCC_OC_PWM1,
        TCCC_OC_PWM2
    } tccc_ocm_e;

    typedef struct packed {
        logic [TCCC_ADDR_W-1:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } tccc_bus_s;
endpackage

// ==== design/tccc_channel_pair.sv ====
// capture/compare channel pair of a 16-bit timer, with slave reset trigger
// assumes counter and update event come from the time-base; samp_tick_i
// pulses once per sampling-clock period for the input filters
// How it works
// - software reads the preload copy of each compare value; output-mode writes also reach shadow while preload is off
// - input mode: counter latched into shadow and preload in the same cycle
// - output mode: preload copied to shadow; shadow compared with counter
// - input sampled, filtered, edge detected, prescaled into capture command
// - capture latches counter, sets channel flag, raises request if enabled
// - capture while channel flag still set also sets overcapture flag
// - channel flag cleared by writing zero or reading captured value
// - overcapture flag cleared only by writing zero
// - direction 00 is output; else input, 01 own pin, value read-only
// - filter needs N equal samples; code 0011 means 8 samples
// - polarity pair 00 rising edge, 01 (pol=1) falling edge
// - prescale code 00 captures on every valid edge
// - captures only while enabled; interrupt only while irq enable set
// - both capture paths may use one pin with opposite edges
// - direction 10 on channel two selects input one
// - only filtered edges of inputs one and two reach slave controller
// - compare mode 101 forces reference high, 100 forces it low
// - while forced, compare still sets flag and interrupt
// - on match: 000 hold, 001 active, 010 inactive, 011 toggle
// - reference active high; polarity bit inverts pin last
// - every compare match sets channel flag, interrupt if enabled
// - preload off: writes reach shadow now; on: at next update event
// - slave reset mode: trigger edge clears counter and sets trigger flag
`timescale 1ns/1ns
module tccc_channel_pair
    import tccc_pkg::*;
#(
    parameter int CNT_W = TCCC_CNT_W
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire tccc_pkg::tccc_bus_s bus_i,
    output logic [15:0] rdata_o,
    input wire logic [CNT_W-1:0] counter_i,
    input wire logic update_event_i,
    input wire logic samp_tick_i,
    input wire logic [1:0] timer_input_pin_i,
    output logic [1:0] channel_output_pin_o,
    output logic [1:0] channel_oe_o,
    output logic counter_reset_o,
    output logic irq_o,
    output logic [1:0] dma_req_o
);
    import tccc_pkg::*;

    logic [15:0] mode_reg;
    logic [7:0] enable_reg;
    logic [15:0] irq_en_reg;
    logic [15:0] slave_reg;
    logic [CNT_W-1:0] preload [2];
    logic [CNT_W-1:0] shadow [2];
    logic [1:0] cc_flag;
    logic [1:0] of_flag;
    logic trg_flag;
    logic [1:0] filt_in;
    logic [1:0] filt_d;
    logic [3:0] filt_cnt [2];
    logic [1:0] edge_fp;
    logic [1:0] cap_evt;
    logic [1:0] cap_ps;
    logic [2:0] psc_cnt [2];
    logic [1:0] out_ref;
    logic [1:0] match;
    logic [1:0] cnt_eq_d;
    logic trig_edge;
    logic ccr_rd;

    // filter code to sample count; a small non-monotonic table
    function automatic logic [3:0] flt_len(input logic [3:0] code);
        unique case (code)
            4'h0: flt_len = 4'h1;
            4'h1: flt_len = 4'h2;
            4'h2: flt_len = 4'h4;
            4'h3: flt_len = 4'h8;
            4'h4: flt_len = 4'h6;
            4'h5: flt_len = 4'h8;
            4'h6: flt_len = 4'h6;
            4'h7: flt_len = 4'h8;
            default: flt_len = 4'hF;
        endcase
    endfunction

    function automatic logic [1:0] dir_of(input int ch, input logic [15:0] m);
        dir_of = m[ch*TCCC_CH2_SHIFT+TCCC_DIR_LSB +: 2];
    endfunction

    logic [1:0] dir [2];
    logic [1:0] en;
    logic [1:0] pol;
    logic [1:0] npol;
    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            dir[c] = dir_of(c, mode_reg);
            en[c] = enable_reg[c*TCCC_EN_CH2_SHIFT+TCCC_EN_BIT];
            pol[c] = enable_reg[c*TCCC_EN_CH2_SHIFT+TCCC_POL_BIT];
            npol[c] = enable_reg[c*TCCC_EN_CH2_SHIFT+TCCC_NPOL_BIT];
        end
    end

    // filter: counts equal samples on the sampling strobe before accepting
    always_ff @(posedge clk_sys_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!rst_n_i)
            begin
                filt_in[c] <= 1'b0;
                filt_cnt[c] <= 4'h0;
            end
            else if (samp_tick_i)
            begin
                if (timer_input_pin_i[c] == filt_in[c])
                    filt_cnt[c] <= 4'h0;
                else if (filt_cnt[c] + 4'h1 >= flt_len(mode_reg[c*8+TCCC_FLT_LSB +: 4]))
                begin
                    filt_in[c] <= timer_input_pin_i[c];
                    filt_cnt[c] <= 4'h0;
                end
                else
                    filt_cnt[c] <= filt_cnt[c] + 4'h1;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            filt_d <= 2'b00;
        else
            filt_d <= filt_in;
    end

    // polarity-selected edges; ch2 may take input one
    always_comb
    begin
        logic s;
        logic r;
        logic f;
        s = 1'b0;
        r = 1'b0;
        f = 1'b0;
        for (int c = 0; c < 2; c++)
        begin
            s = (c == 1 && dir[1] == TCCC_DIR_CROSS) ? 1'b0 : 1'b1;
            r = s ? (filt_in[c] & ~filt_d[c]) : (filt_in[0] & ~filt_d[0]);
            f = s ? (~filt_in[c] & filt_d[c]) : (~filt_in[0] & filt_d[0]);
            edge_fp[c] = (pol[c] & npol[c]) ? (r | f) : (pol[c] ? f : r);
            cap_evt[c] = edge_fp[c] && dir[c] != TCCC_DIR_OUT && en[c];
        end
    end

    // event prescaler; count cleared while channel disabled
    always_ff @(posedge clk_sys_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!rst_n_i || !en[c])
                psc_cnt[c] <= 3'h0;
            else if (cap_evt[c])
                psc_cnt[c] <= cap_ps[c] ? 3'h0 : psc_cnt[c] + 3'h1;
        end
    end

    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            unique case (mode_reg[c*8+TCCC_PSC_LSB +: 2])
                2'h0: cap_ps[c] = cap_evt[c];
                2'h1: cap_ps[c] = cap_evt[c] && psc_cnt[c] == 3'h1;
                2'h2: cap_ps[c] = cap_evt[c] && psc_cnt[c] == 3'h3;
                default: cap_ps[c] = cap_evt[c] && psc_cnt[c] == 3'h7;
            endcase
        end
    end

    // only filtered edges of input one/two drive the slave reset
    always_comb
    begin
        trig_edge = 1'b0;
        if (slave_reg[TCCC_SMS_LSB +: 3] == TCCC_SMS_RESET)
        begin
            if (slave_reg[TCCC_TS_LSB +: 3] == TCCC_TS_IN1)
                trig_edge = (pol[0] ? (~filt_in[0] & filt_d[0]) : (filt_in[0] & ~filt_d[0]));
            else if (slave_reg[TCCC_TS_LSB +: 3] == TCCC_TS_IN2)
                trig_edge = (pol[1] ? (~filt_in[1] & filt_d[1]) : (filt_in[1] & ~filt_d[1]));
        end
    end
    assign counter_reset_o = trig_edge;

    // match registered on entry to equality so one counter value flags once
    always_ff @(posedge clk_sys_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!rst_n_i)
                // start as already equal: an idle counter after reset is no match
                cnt_eq_d[c] <= 1'b1;
            else
                cnt_eq_d[c] <= (counter_i == shadow[c]);
        end
    end

    always_comb
    begin
        for (int c = 0; c < 2; c++)
            match[c] = dir[c] == TCCC_DIR_OUT && counter_i == shadow[c] && !cnt_eq_d[c];
    end

    assign ccr_rd = bus_i.rd;

    always_ff @(posedge clk_sys_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!rst_n_i)
            begin
                preload[c] <= TCCC_RST_CCR;
                shadow[c] <= TCCC_RST_CCR;
            end
            else if (dir[c] != TCCC_DIR_OUT)
            begin
                if (cap_ps[c])
                begin
                    shadow[c] <= counter_i;
                    preload[c] <= counter_i;
                end
            end
            else
            begin
                if (bus_i.wr && bus_i.addr == TCCC_OFF_CCR1 + 4'(c))
                    preload[c] <= bus_i.wdata[CNT_W-1:0];
                if (!mode_reg[c*8+TCCC_OPE_BIT])
                    shadow[c] <= (bus_i.wr && bus_i.addr == TCCC_OFF_CCR1 + 4'(c))
                        ? bus_i.wdata[CNT_W-1:0] : preload[c];
                else if (update_event_i)
                    shadow[c] <= preload[c];
            end
        end
    end

    // flags; hardware set wins over software clear
    always_ff @(posedge clk_sys_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!rst_n_i)
            begin
                cc_flag[c] <= 1'b0;
                of_flag[c] <= 1'b0;
            end
            else
            begin
                if (cap_ps[c] || match[c])
                    cc_flag[c] <= 1'b1;
                else if ((bus_i.wr && bus_i.addr == TCCC_OFF_STATUS
                          && !bus_i.wdata[TCCC_SR_CC1+c])
                         || (ccr_rd && bus_i.addr == TCCC_OFF_CCR1 + 4'(c)))
                    cc_flag[c] <= 1'b0;
                if (cap_ps[c] && cc_flag[c])
                    of_flag[c] <= 1'b1;
                else if (bus_i.wr && bus_i.addr == TCCC_OFF_STATUS
                         && !bus_i.wdata[TCCC_SR_OF1+c])
                    of_flag[c] <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            trg_flag <= 1'b0;
        else if (trig_edge)
            trg_flag <= 1'b1;
        else if (bus_i.wr && bus_i.addr == TCCC_OFF_STATUS && !bus_i.wdata[TCCC_SR_TRG])
            trg_flag <= 1'b0;
    end

    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            irq_o <= 1'b0;
            dma_req_o <= 2'b00;
        end
        else
        begin
            irq_o <= (cc_flag[0] & irq_en_reg[TCCC_SR_CC1])
                | (cc_flag[1] & irq_en_reg[TCCC_SR_CC2])
                | (trg_flag & irq_en_reg[TCCC_SR_TRG]);
            dma_req_o[0] <= (cap_ps[0] | match[0]) & irq_en_reg[TCCC_SR_CC1 + 8];
            dma_req_o[1] <= (cap_ps[1] | match[1]) & irq_en_reg[TCCC_SR_CC2 + 8];
        end
    end

    // reference waveform; update event has no effect on it
    always_ff @(posedge clk_sys_i)
    begin
        for (int c = 0; c < 2; c++)
        begin
            if (!rst_n_i)
                out_ref[c] <= 1'b0;
            else
            begin
                unique case (tccc_ocm_e'(mode_reg[c*8+TCCC_OCM_LSB +: 3]))
                    TCCC_OC_ACTIVE: if (match[c]) out_ref[c] <= 1'b1;
                    TCCC_OC_INACTIVE: if (match[c]) out_ref[c] <= 1'b0;
                    TCCC_OC_TOGGLE: if (match[c]) out_ref[c] <= ~out_ref[c];
                    TCCC_OC_FORCE_LOW: out_ref[c] <= 1'b0;
                    TCCC_OC_FORCE_HIGH: out_ref[c] <= 1'b1;
                    // pwm modes belong to another block: hold
                    default: out_ref[c] <= out_ref[c];
                endcase
            end
        end
    end

    always_comb
    begin
        for (int c = 0; c < 2; c++)
        begin
            channel_output_pin_o[c] = out_ref[c] ^ pol[c];
            channel_oe_o[c] = en[c] && dir[c] == TCCC_DIR_OUT;
        end
    end

    // configuration registers; mode fields set direction, prescaler, filter, compare mode and preload
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            mode_reg <= TCCC_RST_REG;
            enable_reg <= 8'h00;
            irq_en_reg <= TCCC_RST_REG;
            slave_reg <= TCCC_RST_REG;
        end
        else if (bus_i.wr)
        begin
            unique case (bus_i.addr)
                TCCC_OFF_MODE: mode_reg <= bus_i.wdata;
                TCCC_OFF_ENABLE: enable_reg <= bus_i.wdata[7:0];
                TCCC_OFF_IRQEN: irq_en_reg <= bus_i.wdata;
                TCCC_OFF_SLAVE: slave_reg <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // read data one cycle after the strobe; unmapped reads return zero
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
            rdata_o <= 16'h0000;
        else if (bus_i.rd)
        begin
            unique case (bus_i.addr)
                TCCC_OFF_MODE: rdata_o <= mode_reg;
                TCCC_OFF_ENABLE: rdata_o <= {8'h00, enable_reg};
                TCCC_OFF_IRQEN: rdata_o <= irq_en_reg;
                TCCC_OFF_STATUS:
                    rdata_o <= (16'(of_flag[1]) << TCCC_SR_OF2)
                        | (16'(of_flag[0]) << TCCC_SR_OF1) | (16'(trg_flag) << TCCC_SR_TRG)
                        | (16'(cc_flag[1]) << TCCC_SR_CC2) | (16'(cc_flag[0]) << TCCC_SR_CC1);
                TCCC_OFF_CCR1: rdata_o <= 16'(preload[0]);
                TCCC_OFF_CCR2: rdata_o <= 16'(preload[1]);
                TCCC_OFF_SLAVE: rdata_o <= slave_reg;
                default: rdata_o <= 16'h0000;
            endcase
        end
        else
            rdata_o <= 16'h0000;
    end
endmodule // tccc_channel_pair

// ==== sim/tccc_pin_model.sv ====
// signal source on the timer input pins, bouncing after each level change
// assumes the bench sets the wanted level by non-blocking assignment
`timescale 1ns/1ns
module tccc_pin_model
(
    input wire logic clk_i,
    input wire logic [1:0] level_i,
    output logic [1:0] pin_o
);
    logic [1:0] goal = 2'b00;
    logic [1:0] pin_q = 2'b00;
    logic [1:0][2:0] bnc = '0;

    assign pin_o = pin_q;

    // a real contact bounces, so the filter is never handed a clean edge
    always @(posedge clk_i)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (level_i[i] !== goal[i])
                bnc[i] <= 3'h4;
            else if (bnc[i] != 3'h0)
                bnc[i] <= bnc[i] - 3'h1;
            pin_q[i] <= bnc[i][0] ? ~level_i[i] : level_i[i];
        end
        goal <= level_i;
    end
endmodule // tccc_pin_model

// ==== sim/tccc_channel_pair_chk.sv ====
// port checker for the capture/compare channel pair
// assumes the register map of tccc_pkg and one kernel clock domain
`timescale 1ns/1ns
module tccc_channel_pair_chk
#(
    parameter int CNT_W = tccc_pkg::TCCC_CNT_W
)
(
    input wire logic clk_sys_i,
    input wire logic rst_n_i,
    input wire tccc_pkg::tccc_bus_s bus_i,
    input wire logic [15:0] rdata_o,
    input wire logic [CNT_W-1:0] counter_i,
    input wire logic update_event_i,
    input wire logic samp_tick_i,
    input wire logic [1:0] timer_input_pin_i,
    input wire logic [1:0] channel_output_pin_o,
    input wire logic [1:0] channel_oe_o,
    input wire logic counter_reset_o,
    input wire logic irq_o,
    input wire logic [1:0] dma_req_o
);
    import tccc_pkg::*;
    logic [15:0] mode_q;
    logic [15:0] en_q;
    logic [15:0] ie_q;
    logic [15:0] slv_q;
    logic [1:0] stay;

    // shadow of the configuration, seen from the bus only
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i)
        begin
            mode_q <= TCCC_RST_REG;
            en_q <= TCCC_RST_REG;
            ie_q <= TCCC_RST_REG;
            slv_q <= TCCC_RST_REG;
        end
        else if (bus_i.wr)
        begin
            case (bus_i.addr)
                TCCC_OFF_MODE: mode_q <= bus_i.wdata;
                TCCC_OFF_ENABLE: en_q <= bus_i.wdata;
                TCCC_OFF_IRQEN: ie_q <= bus_i.wdata;
                TCCC_OFF_SLAVE: slv_q <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // cycles since mode or enable last changed, saturating
    always_ff @(posedge clk_sys_i)
    begin
        if (!rst_n_i || (bus_i.wr && bus_i.addr <= TCCC_OFF_ENABLE))
            stay <= 2'h0;
        else if (stay != 2'h3)
            stay <= stay + 2'h1;
    end

    default clocking cb @(posedge clk_sys_i);
    endclocking
    default disable iff (!rst_n_i);

    sequence s_trig_seen;
        counter_reset_o && ie_q[TCCC_SR_TRG];
    endsequence
    sequence s_irq_follows;
        ##[1:2] irq_o;
    endsequence

    property p_rdata_idle;
        !$past(bus_i.rd) |-> rdata_o == 16'h0000;
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read answer");
    property p_oe;
        channel_oe_o == {en_q[4] && mode_q[9:8] == TCCC_DIR_OUT,
            en_q[0] && mode_q[1:0] == TCCC_DIR_OUT};
    endproperty
    a_oe: assert property (p_oe)
        else $error("output enable does not follow direction and enable");
    property p_force;
        stay >= 2'h2 && en_q[0] && mode_q[1:0] == TCCC_DIR_OUT && mode_q[6:5] == 2'b10
            |-> channel_output_pin_o[0] == (mode_q[4] ^ en_q[1]);
    endproperty
    a_force: assert property (p_force)
        else $error("forced level wrong on output pin");
    property p_frozen;
        stay >= 2'h2 && en_q[0] && mode_q[1:0] == TCCC_DIR_OUT && mode_q[6:4] == 3'h0
            |-> $stable(channel_output_pin_o[0]);
    endproperty
    a_frozen: assert property (p_frozen)
        else $error("frozen output changed");
    property p_trig_sel;
        counter_reset_o |-> slv_q[2:0] == TCCC_SMS_RESET
            && (slv_q[6:4] == TCCC_TS_IN1 || slv_q[6:4] == TCCC_TS_IN2);
    endproperty
    a_trig_sel: assert property (p_trig_sel)
        else $error("counter reset without reset mode and input trigger");
    property p_trig_pulse;
        counter_reset_o |=> !counter_reset_o;
    endproperty
    a_trig_pulse: assert property (p_trig_pulse)
        else $error("counter reset longer than one cycle");
    property p_trig_irq;
        s_trig_seen |-> s_irq_follows;
    endproperty
    a_trig_irq: assert property (p_trig_irq)
        else $error("trigger did not raise interrupt");
    property p_dma_en;
        dma_req_o[0] |-> $past(ie_q[9]) && !$past(dma_req_o[0]);
    endproperty
    a_dma_en: assert property (p_dma_en)
        else $error("dma request without enable or too long");
    property p_irq_off;
        ie_q == 16'h0000 && $past(ie_q) == 16'h0000 |-> !irq_o;
    endproperty
    a_irq_off: assert property (p_irq_off)
        else $error("interrupt with all enables off");
endmodule // tccc_channel_pair_chk

bind tccc_channel_pair tccc_channel_pair_chk #(.CNT_W(CNT_W)) u_chk (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus_i), .rdata_o(rdata_o),
    .counter_i(counter_i), .update_event_i(update_event_i), .samp_tick_i(samp_tick_i),
    .timer_input_pin_i(timer_input_pin_i), .channel_output_pin_o(channel_output_pin_o),
    .channel_oe_o(channel_oe_o), .counter_reset_o(counter_reset_o), .irq_o(irq_o),
    .dma_req_o(dma_req_o));

// ==== sim/timer_capture_compare_channel_tb_top.sv ====
// self-checking bench for the capture/compare channel pair
// assumes the pin model drives the input pins and the bench the time-base
`timescale 1ns/1ns
module timer_capture_compare_channel_tb_top;
    import tccc_pkg::*;
    localparam logic [15:0] CC1 = 16'h0001 << TCCC_SR_CC1;
    localparam logic [15:0] OF1 = 16'h0001 << TCCC_SR_OF1;
    logic clk_sys_i = 1'b0;
    logic rst_n_i = 1'b0;
    tccc_bus_s bus = '0;
    logic [15:0] cnt = 16'h0000;
    logic upd = 1'b0;
    logic tick = 1'b0;
    logic [1:0] lvl = 2'b00;
    logic [1:0] pin;
    logic [1:0] opin;
    logic [15:0] rdata;
    logic trig;
    logic irq;
    logic [15:0] rv;
    int miscompares = 0;
    int samples_checked = 0;
    int trigs = 0;

    always #5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i)
        tick <= ~tick;
    always @(posedge clk_sys_i)
        if (trig === 1'b1)
            trigs <= trigs + 1;

    tccc_pin_model u_pins (.clk_i(clk_sys_i), .level_i(lvl), .pin_o(pin));
    tccc_channel_pair dut (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .bus_i(bus),
        .rdata_o(rdata), .counter_i(cnt), .update_event_i(upd), .samp_tick_i(tick),
        .timer_input_pin_i(pin), .channel_output_pin_o(opin), .channel_oe_o(),
        .counter_reset_o(trig), .irq_o(irq), .dma_req_o());

    task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp)
        begin
            miscompares++;
            $display("CHECK FAILED t=%0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys_i);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge clk_sys_i);
        bus.wr <= 1'b0;
    endtask
    task automatic rdc(input logic [3:0] a, input logic [15:0] exp, input string what);
        @(posedge clk_sys_i);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge clk_sys_i);
        bus.rd <= 1'b0;
        #1;
        chk(rdata, exp, what);
    endtask
    // n cycles cover bounce plus eight filter samples at every other cycle
    task automatic pin_to(input logic l, input logic [15:0] c, input int n);
        @(posedge clk_sys_i);
        lvl <= {1'b0, l};
        cnt <= c;
        repeat (n) @(posedge clk_sys_i);
    endtask
    task automatic sweep(input logic [15:0] a);
        for (int i = 0; i < 5; i++)
            @(posedge clk_sys_i) cnt <= a + 16'(i);
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask

    task automatic t_reset;
        for (int a = 0; a < 8; a++)
            rdc(4'(a), TCCC_RST_REG, "reset value");
    endtask
    task automatic t_capture;
        wr(TCCC_OFF_MODE, 16'h0131);
        wr(TCCC_OFF_IRQEN, 16'h0202);
        wr(TCCC_OFF_ENABLE, 16'h0001);
        pin_to(1'b1, 16'h0011, 6);
        pin_to(1'b0, 16'h0011, 40);
        rdc(TCCC_OFF_STATUS, 16'h0000, "glitch captured");
        pin_to(1'b1, 16'h1234, 40);
        chk({15'h0000, irq}, 16'h0001, "irq on capture");
        rdc(TCCC_OFF_STATUS, CC1, "capture flag");
        pin_to(1'b0, 16'h0000, 40);
        pin_to(1'b1, 16'h2345, 40);
        rdc(TCCC_OFF_STATUS, CC1 | OF1, "overcapture");
        wr(TCCC_OFF_CCR1, 16'hBEEF);
        rdc(TCCC_OFF_CCR1, 16'h2345, "captured value");
        rdc(TCCC_OFF_STATUS, OF1, "read clears flag");
        wr(TCCC_OFF_STATUS, 16'h0000);
        rdc(TCCC_OFF_STATUS, 16'h0000, "write zero clears");
        wr(TCCC_OFF_ENABLE, 16'h0000);
        pin_to(1'b0, 16'h0000, 40);
        pin_to(1'b1, 16'h0001, 40);
        rdc(TCCC_OFF_STATUS, 16'h0000, "capture while disabled");
        wr(TCCC_OFF_MODE, 16'h0135);
        wr(TCCC_OFF_ENABLE, 16'h0001);
        pin_to(1'b0, 16'h0000, 40);
        pin_to(1'b1, 16'h3333, 40);
        rdc(TCCC_OFF_STATUS, 16'h0000, "prescale first edge");
        pin_to(1'b0, 16'h0000, 40);
        pin_to(1'b1, 16'h4444, 40);
        rdc(TCCC_OFF_CCR1, 16'h4444, "prescale second edge");
        wr(TCCC_OFF_MODE, 16'h0139);
        for (int i = 1; i <= 4; i++)
        begin
            pin_to(1'b0, 16'h0002, 40);
            pin_to(1'b1, 16'(i), 40);
            if (i == 3)
                rdc(TCCC_OFF_CCR1, 16'h4444, "prescale by four early");
        end
        rdc(TCCC_OFF_CCR1, 16'h0004, "prescale by four");
    endtask
    task automatic t_pwm_in;
        int n;
        wr(TCCC_OFF_ENABLE, 16'h0000);
        wr(TCCC_OFF_STATUS, 16'h0000);
        wr(TCCC_OFF_MODE, 16'h3231);
        wr(TCCC_OFF_SLAVE, 16'h0054);
        wr(TCCC_OFF_IRQEN, 16'h0046);
        wr(TCCC_OFF_ENABLE, 16'h0031);
        n = trigs;
        pin_to(1'b0, 16'h0100, 40);
        pin_to(1'b1, 16'h0500, 40);
        pin_to(1'b0, 16'h0700, 40);
        rdc(TCCC_OFF_CCR1, 16'h0500, "period capture");
        rdc(TCCC_OFF_CCR2, 16'h0700, "cross capture");
        chk(16'(trigs - n), 16'h0001, "reset pulses");
        rdc(TCCC_OFF_STATUS, 16'h0440, "trigger and overcapture");
    endtask
    task automatic t_compare;
        logic [15:0] exp;
        wr(TCCC_OFF_ENABLE, 16'h0000);
        wr(TCCC_OFF_SLAVE, 16'h0000);
        wr(TCCC_OFF_IRQEN, 16'h0002);
        wr(TCCC_OFF_MODE, 16'h0000);
        wr(TCCC_OFF_ENABLE, 16'h0001);
        wr(TCCC_OFF_CCR1, 16'h0050);
        for (int c = 0; c < 4; c++)
        begin
            wr(TCCC_OFF_STATUS, 16'h0000);
            wr(TCCC_OFF_MODE, (c == 2) ? 16'h0050 : 16'h0040);
            sweep(16'h004E);
            chk({15'h0000, opin[0]}, (c == 2) ? 16'h0001 : 16'h0000, "forced");
            rdc(TCCC_OFF_STATUS, CC1, "match while forced");
            wr(TCCC_OFF_STATUS, 16'h0000);
            wr(TCCC_OFF_MODE, 16'(c) << TCCC_OCM_LSB);
            sweep(16'h004E);
            exp = (c == 1 || c == 3) ? 16'h0001 : 16'h0000;
            chk({15'h0000, opin[0]}, exp, "match action");
            rdc(TCCC_OFF_STATUS, CC1, "match flag");
        end
        wr(TCCC_OFF_ENABLE, 16'h0003);
        #1;
        chk({15'h0000, opin[0]}, 16'h0000, "inverted pin");
        wr(TCCC_OFF_STATUS, 16'h0000);
        wr(TCCC_OFF_MODE, 16'h0038);
        wr(TCCC_OFF_CCR1, 16'h0060);
        sweep(16'h005E);
        rdc(TCCC_OFF_STATUS, 16'h0000, "preload held");
        @(posedge clk_sys_i) upd <= 1'b1;
        @(posedge clk_sys_i) upd <= 1'b0;
        sweep(16'h005E);
        rdc(TCCC_OFF_STATUS, CC1, "preload loaded");
    endtask

    task automatic close_out;
        $display("comparisons %0d, mismatches %0d", samples_checked, miscompares);
        if (miscompares == 0 && samples_checked > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask

    initial
    begin
        repeat (10) @(posedge clk_sys_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_capture();
        t_pwm_in();
        t_compare();
        close_out();
    end
    initial
    begin
        repeat (20000) @(posedge clk_sys_i);
        miscompares++;
        close_out();
    end
endmodule // timer_capture_compare_channel_tb_top
